// >>> logic/fpwd_pkg.sv
// package for the flash page window decoder: constants and carrier types
// Notes on behaviour
// - no off-chip page extension, internal pages only
// - window 0x8000-0xBFFF uses page select register
// - top range maps page 3f when enabled
// - middle range maps 3e above 16K flash unless half-map set
// - bottom range maps 3d above 32K flash
// - window aliases page select by flash size
package fpwd_pkg;
  localparam int ADDR_W = 16;
  localparam int PAGE_W = 6;
  localparam int OFFS_W = 14;
  localparam logic [1:0] RANGE_BOTTOM = 2'h0;
  localparam logic [1:0] RANGE_MIDDLE = 2'h1;
  localparam logic [1:0] RANGE_WINDOW = 2'h2;
  localparam logic [1:0] RANGE_TOP    = 2'h3;
  localparam logic [5:0] PAGE_TOP     = 6'h3f;
  localparam logic [5:0] PAGE_MIDDLE  = 6'h3e;
  localparam logic [5:0] PAGE_BOTTOM  = 6'h3d;
  localparam logic [5:0] PAGE_ZERO    = 6'h00;
  localparam logic [5:0] MASK_128K    = 6'h07;
  localparam logic [5:0] MASK_64K     = 6'h03;
  localparam logic [5:0] MASK_32K     = 6'h01;
  localparam logic [5:0] MASK_16K     = 6'h00;
  localparam logic [1:0] PAGE_KEEP_W_SEL = 2'h0;
  localparam int FLASH_KB_DEFAULT = 128;
  localparam int KB_16  = 16;
  localparam int KB_32  = 32;
  localparam int KB_64  = 64;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } fpwd_req_type;

  typedef struct packed {
    logic              hit;
    logic [PAGE_W-1:0] page;
    logic [OFFS_W-1:0] offset;
  } fpwd_map_type;

  typedef struct packed {
    logic [PAGE_W-1:0] page_sel;
    fpwd_map_type      map;
  } fpwd_state_type;
endpackage

// >>> logic/fpwd_decode.sv
// flash page window decoder: cpu address to internal flash page and offset
`timescale 1ns/10ps
module fpwd_decode #(
  parameter int FLASH_KB = fpwd_pkg::FLASH_KB_DEFAULT
) (
  input  wire logic                         mclk,
  input  wire logic                         nrst,
  input  wire fpwd_pkg::fpwd_req_type       req,
  input  wire logic                         page_sel_we,
  input  wire logic [fpwd_pkg::PAGE_W-1:0]  page_sel_wdata,
  input  wire logic                         flash_enable_bit,
  input  wire logic                         flash_half_map_bit,
  output fpwd_pkg::fpwd_map_type            map,
  output logic [fpwd_pkg::PAGE_W-1:0]       program_page_select
);
  import fpwd_pkg::*;

  fpwd_state_type state_reg;
  fpwd_state_type state_next;

  // size-dependent alias mask; the window only ever sees top pages
  function automatic logic [PAGE_W-1:0] size_mask(input int kb);
    if (kb <= KB_16) begin
      return MASK_16K;
    end else if (kb <= KB_32) begin
      return MASK_32K;
    end else if (kb <= KB_64) begin
      return MASK_64K;
    end else begin
      return MASK_128K;
    end
  endfunction

  localparam logic [PAGE_W-1:0] WIN_MASK = size_mask(FLASH_KB);
  localparam logic HAS_BOTTOM = (FLASH_KB > KB_32);
  localparam logic HAS_MIDDLE = (FLASH_KB > KB_16);

  // page that the window shows; only the low select bits survive aliasing
  function automatic logic [PAGE_W-1:0] window_page(
    input logic [PAGE_W-1:0] sel
  );
    return (PAGE_TOP & ~WIN_MASK) | (sel & WIN_MASK);
  endfunction

  // the smallest part has one window page; even selects miss flash
  function automatic logic window_hit(input logic [PAGE_W-1:0] sel);
    if (WIN_MASK == MASK_16K) begin
      return sel[0];
    end else begin
      return 1'b1;
    end
  endfunction

  // fixed page of a non-window range; the select register is not an input
  function automatic logic [PAGE_W-1:0] fixed_page(input logic [1:0] rng);
    if (rng == RANGE_TOP) begin
      return PAGE_TOP;
    end else if (rng == RANGE_MIDDLE) begin
      return PAGE_MIDDLE;
    end else if (rng == RANGE_BOTTOM) begin
      return PAGE_BOTTOM;
    end else begin
      return PAGE_ZERO;
    end
  endfunction

  // fixed ranges answer only with flash enabled; small parts lack pages
  function automatic logic fixed_hit(input logic [1:0] rng,
                                     input logic       en,
                                     input logic       hm);
    if (rng == RANGE_TOP) begin
      return en;
    end else if (rng == RANGE_MIDDLE) begin
      return en && !hm && HAS_MIDDLE;
    end else if (rng == RANGE_BOTTOM) begin
      return en && HAS_BOTTOM;
    end else begin
      return 1'b0;
    end
  endfunction

  logic [1:0] range_sel;
  assign range_sel = req.addr[ADDR_W-1:OFFS_W];

  always_comb begin
    state_next = state_reg;
    if (page_sel_we) begin
      // a load lands at the edge, so an access in the same cycle
      // still sees the old select
      state_next.page_sel = page_sel_wdata;
    end
    state_next.map.hit    = 1'b0;
    state_next.map.page   = PAGE_ZERO;
    // only internal page and offset leave the block; no address extension
    state_next.map.offset = req.addr[OFFS_W-1:0];
    if (req.valid) begin
      if (range_sel == RANGE_WINDOW) begin
        // the window does not depend on the flash enable
        state_next.map.hit  = window_hit(state_reg.page_sel);
        state_next.map.page = window_page(state_reg.page_sel);
      end else begin
        state_next.map.hit  = fixed_hit(range_sel, flash_enable_bit,
                                        flash_half_map_bit);
        state_next.map.page = fixed_page(range_sel);
      end
    end
    // a miss reports page zero so a stale page never looks valid
    if (!state_next.map.hit) begin
      state_next.map.page = PAGE_ZERO;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign map                 = state_reg.map;
  assign program_page_select = state_reg.page_sel;

  // top range follows the enable alone
  AST_TOP_PAGE: assert property (@(posedge mclk) disable iff (!nrst)
    req.valid && req.addr[ADDR_W-1:OFFS_W] == RANGE_TOP && flash_enable_bit
    |=> map.hit && map.page == PAGE_TOP)
    else $error("top range did not map its page");

  // middle range needs the enable and a clear half-map bit
  AST_MID_PAGE: assert property (@(posedge mclk) disable iff (!nrst)
    req.valid && req.addr[ADDR_W-1:OFFS_W] == RANGE_MIDDLE
    |=> map.hit == $past(flash_enable_bit && !flash_half_map_bit
                         && HAS_MIDDLE))
    else $error("middle range hit wrong");

  // half-map set always removes flash from the middle range
  AST_MID_OFF: assert property (@(posedge mclk) disable iff (!nrst)
    req.valid && req.addr[ADDR_W-1:OFFS_W] == RANGE_MIDDLE
    && flash_half_map_bit
    |=> !map.hit)
    else $error("middle range mapped with half-map set");

  // bottom range exists only on the larger parts
  AST_BOT_PAGE: assert property (@(posedge mclk) disable iff (!nrst)
    req.valid && req.addr[ADDR_W-1:OFFS_W] == RANGE_BOTTOM
    |=> map.hit == $past(flash_enable_bit && HAS_BOTTOM))
    else $error("bottom range hit wrong");

  // no fixed range maps flash while the enable is clear
  AST_FIXED_OFF: assert property (@(posedge mclk) disable iff (!nrst)
    req.valid && req.addr[ADDR_W-1:OFFS_W] != RANGE_WINDOW
    && !flash_enable_bit
    |=> !map.hit)
    else $error("fixed range mapped with flash disabled");

  // window page is the top pages with the select in the low bits
  AST_WIN_PAGE: assert property (@(posedge mclk) disable iff (!nrst)
    req.valid && req.addr[ADDR_W-1:OFFS_W] == RANGE_WINDOW
    && WIN_MASK != MASK_16K
    |=> map.hit && map.page == ((PAGE_TOP & ~WIN_MASK)
                                | ($past(program_page_select) & WIN_MASK)))
    else $error("window page wrong");

  // window hits on the larger parts even with flash disabled
  AST_WIN_NO_EN: assert property (@(posedge mclk) disable iff (!nrst)
    req.valid && req.addr[ADDR_W-1:OFFS_W] == RANGE_WINDOW
    && WIN_MASK != MASK_16K && !flash_enable_bit
    |=> map.hit)
    else $error("window missed with flash disabled");

  // smallest part: odd selects only
  AST_WIN_16K: assert property (@(posedge mclk) disable iff (!nrst)
    req.valid && req.addr[ADDR_W-1:OFFS_W] == RANGE_WINDOW
    && WIN_MASK == MASK_16K
    |=> map.hit == $past(program_page_select[0]))
    else $error("smallest window hit wrong");

  AST_SEL_LOAD: assert property (@(posedge mclk) disable iff (!nrst)
    page_sel_we |=> program_page_select == $past(page_sel_wdata))
    else $error("page select not loaded");

  // the select only changes on a load
  AST_SEL_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    !page_sel_we |=> $stable(program_page_select))
    else $error("page select changed without a load");

  // fixed ranges give their own page whatever the select holds
  AST_FIXED_IGNORE: assert property (@(posedge mclk) disable iff (!nrst)
    req.valid && req.addr[ADDR_W-1:OFFS_W] != RANGE_WINDOW
    |=> map.page == (map.hit
                     ? fixed_page($past(req.addr[ADDR_W-1:OFFS_W]))
                     : PAGE_ZERO))
    else $error("fixed range followed page select");

  AST_OFFSET: assert property (@(posedge mclk) disable iff (!nrst)
    1'b1 |=> map.offset == $past(req.addr[OFFS_W-1:0]))
    else $error("offset not passed through");

  AST_IDLE: assert property (@(posedge mclk) disable iff (!nrst)
    !req.valid |=> !map.hit)
    else $error("hit without request");

  AST_MISS_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
    !map.hit |-> map.page == PAGE_ZERO)
    else $error("page shown on a miss");

  COV_WIN: cover property (@(posedge mclk) disable iff (!nrst)
    req.valid && req.addr[ADDR_W-1:OFFS_W] == RANGE_WINDOW ##1 map.hit);
  COV_TOP: cover property (@(posedge mclk) disable iff (!nrst)
    req.valid && req.addr[ADDR_W-1:OFFS_W] == RANGE_TOP ##1 map.hit);
  COV_HALF: cover property (@(posedge mclk) disable iff (!nrst)
    req.valid && req.addr[ADDR_W-1:OFFS_W] == RANGE_MIDDLE
    && flash_half_map_bit);
  COV_BOTTOM: cover property (@(posedge mclk) disable iff (!nrst)
    req.valid && req.addr[ADDR_W-1:OFFS_W] == RANGE_BOTTOM ##1 map.hit);
  COV_LOAD_WIN: cover property (@(posedge mclk) disable iff (!nrst)
    page_sel_we && req.valid
    && req.addr[ADDR_W-1:OFFS_W] == RANGE_WINDOW);
endmodule // fpwd_decode

// >>> test/fpwd_core_model.sv
// processor core model: issues flash accesses and page select loads
`timescale 1ns/10ps
module fpwd_core_model (
  input  wire logic                  mclk,
  output fpwd_pkg::fpwd_req_type     req,
  output logic                       page_sel_we,
  output logic [fpwd_pkg::PAGE_W-1:0] page_sel_wdata
);
  import fpwd_pkg::*;
  initial begin
    req = '0;
    page_sel_we = 1'b0;
    page_sel_wdata = '0;
  end
  // released lines show inverted old value so a stale one never matches
  task automatic drive(input logic v, input logic [15:0] a,
                       input logic w, input logic [5:0] s);
    @(negedge mclk);
    req.valid = v;
    req.addr = v ? a : ~req.addr;
    page_sel_we = w;
    page_sel_wdata = w ? s : ~page_sel_wdata;
  endtask
endmodule // fpwd_core_model

// >>> test/flash_page_window_decode_bench.sv
// bench for the flash page window decoder
`timescale 1ns/10ps
module flash_page_window_decode_bench;
  import fpwd_pkg::*;
  typedef struct packed {
    logic [5:0] sel; logic en; logic hm;
    logic [15:0] addr; logic hit; logic [5:0] pg;
  } fpwd_row_type;
  logic mclk = 1'b0, nrst = 1'b0, en = 1'b0, hm = 1'b0;
  fpwd_req_type req;
  logic we;
  logic [5:0] wd, sel;
  fpwd_map_type map;
  fpwd_map_type map16;
  fpwd_map_type map32;
  int failures = 0, n_checks = 0;
  fpwd_row_type rows [9] = '{
    '{6'h05,1'h1,1'h0,16'h8123,1'h1,6'h3d},
    '{6'h3a,1'h0,1'h0,16'h8000,1'h1,6'h3a},
    '{6'h0f,1'h1,1'h1,16'hbfff,1'h1,6'h3f},
    '{6'h00,1'h1,1'h0,16'hc000,1'h1,6'h3f},
    '{6'h05,1'h0,1'h0,16'hffff,1'h0,6'h00},
    '{6'h12,1'h1,1'h0,16'h4000,1'h1,6'h3e},
    '{6'h12,1'h1,1'h1,16'h7fff,1'h0,6'h00},
    '{6'h3b,1'h1,1'h0,16'h0000,1'h1,6'h3d},
    '{6'h3b,1'h0,1'h0,16'h3fff,1'h0,6'h00}};
  fpwd_core_model u_core (.mclk(mclk), .req(req), .page_sel_we(we),
                          .page_sel_wdata(wd));
  fpwd_decode u_dut (.mclk(mclk), .nrst(nrst), .req(req), .page_sel_we(we),
    .page_sel_wdata(wd), .flash_enable_bit(en), .flash_half_map_bit(hm),
    .map(map), .program_page_select(sel));
  // smaller parts share the stimulus to reach the 16K and 32K alias widths
  fpwd_decode #(.FLASH_KB(KB_16)) u_dut_16k (.mclk(mclk), .nrst(nrst),
    .req(req), .page_sel_we(we), .page_sel_wdata(wd),
    .flash_enable_bit(en), .flash_half_map_bit(hm), .map(map16),
    .program_page_select());
  fpwd_decode #(.FLASH_KB(KB_32)) u_dut_32k (.mclk(mclk), .nrst(nrst),
    .req(req), .page_sel_we(we), .page_sel_wdata(wd),
    .flash_enable_bit(en), .flash_half_map_bit(hm), .map(map32),
    .program_page_select());
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic chk_map(input fpwd_map_type g, input fpwd_map_type e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_sel(input logic [5:0] g, input logic [5:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    chk_sel(sel, 6'h00);
    foreach (rows[i]) begin
      u_core.drive(1'b0, 16'h0, 1'b1, rows[i].sel);
      u_core.drive(1'b1, rows[i].addr, 1'b0, 6'h0);
      en = rows[i].en;
      hm = rows[i].hm;
      chk_sel(sel, rows[i].sel);
      @(posedge mclk);
      #1 chk_map(map, {rows[i].hit, rows[i].pg, rows[i].addr[13:0]});
    end
    // load and window access together: old select applies this cycle
    u_core.drive(1'b1, 16'h8001, 1'b1, 6'h00);
    u_core.drive(1'b1, 16'h8002, 1'b0, 6'h0);
    #1 chk_map(map, {1'b1, 6'h3b, 14'h0001});
    chk_map(map16, {1'b1, 6'h3f, 14'h0001});
    chk_map(map32, {1'b1, 6'h3f, 14'h0001});
    @(posedge mclk);
    #1 chk_map(map, {1'b1, 6'h38, 14'h0002});
    chk_map(map16, {1'b0, 6'h00, 14'h0002});
    chk_map(map32, {1'b1, 6'h3e, 14'h0002});
    // fixed pages that the smaller parts lack
    u_core.drive(1'b1, 16'h0000, 1'b0, 6'h0);
    en = 1'b1;
    hm = 1'b0;
    @(posedge mclk);
    #1 chk_map(map, {1'b1, 6'h3d, 14'h0000});
    chk_map(map32, {1'b0, 6'h00, 14'h0000});
    u_core.drive(1'b1, 16'h4000, 1'b0, 6'h0);
    @(posedge mclk);
    #1 chk_map(map32, {1'b1, 6'h3e, 14'h0000});
    chk_map(map16, {1'b0, 6'h00, 14'h0000});
    @(negedge mclk);
    nrst = 1'b0;
    #1 chk_map(map, '0);
    chk_sel(sel, 6'h00);
    // release again mid-run: select restarts at zero
    @(negedge mclk);
    nrst = 1'b1;
    u_core.drive(1'b1, 16'h8000, 1'b0, 6'h0);
    @(posedge mclk);
    #1 chk_map(map, {1'b1, 6'h38, 14'h0000});
    report_and_stop;
  end
endmodule // flash_page_window_decode_bench
